// >>> fam_pkg.sv
`default_nettype none
package fam_pkg;
  localparam int ADDR_W = 24;
  localparam int ARRAY_W = 22;
  localparam int ARRAY_BYTES = 4194304;
  localparam int BLOCK_COUNT = 64;
  localparam int SECTOR_COUNT = 1024;
  localparam int PAGE_BYTES = 256;
  localparam int SEC_REG_COUNT = 4;
  localparam int SEC_REG_BYTES = 256;
  localparam int BLOCK_LSB = 16;
  localparam int SECTOR_LSB = 12;
  localparam int PAGE_LSB = 8;
  localparam int SEC_SEL_LSB = 12;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] PARAM_READ_OPCODE = 8'h5a;
  localparam logic [15:0] PARAM_HDR_BASE = 16'h0000;
  localparam logic [15:0] PARAM_HDR_RSVD = 16'h0010;
  localparam logic [15:0] PARAM_TBL_BASE = 16'h0030;
  localparam logic [15:0] PARAM_SPACE_END = 16'h006f;
  localparam logic [15:0] PARAM_RSVD_END = 16'h00ff;
  localparam logic [7:0] SIG_0 = 8'h53;
  localparam logic [7:0] SIG_1 = 8'h46;
  localparam logic [7:0] SIG_2 = 8'h44;
  localparam logic [7:0] SIG_3 = 8'h50;
  localparam logic [7:0] HDR_MINOR_REV = 8'h06;
  localparam logic [7:0] HDR_MAJOR_REV = 8'h01;
  localparam logic [7:0] HDR_COUNT = 8'h00;
  localparam logic [7:0] HDR_UNUSED = 8'hff;
  localparam logic [7:0] TBL_ID_LSB = 8'h00;
  localparam logic [7:0] TBL_MINOR_REV = 8'h00;

  typedef enum logic [3:0] {
    op_read_array = 4'h0,
    op_prog_start = 4'h1,
    op_prog_data = 4'h2,
    op_erase_sector = 4'h3,
    op_erase_block = 4'h4,
    op_erase_chip = 4'h5,
    op_read_sec = 4'h6,
    op_prog_sec = 4'h7,
    op_erase_sec = 4'h8,
    op_read_param = 4'h9
  } fam_op_type;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_erase = 2'b01
  } fam_state_type;

  typedef struct packed {
    logic valid;
    fam_op_type op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fam_req_type;

  typedef struct packed {
    logic ready;
    logic busy;
    logic rvalid;
    logic [7:0] rdata;
    logic ignored;
  } fam_rsp_type;

  // factory parameter space; also the content of security register zero
  function automatic logic [7:0] fam_param_byte(input logic [15:0] a);
    logic [7:0] b;
    b = ERASED_BYTE;
    if (a > PARAM_RSVD_END)
      b = ERASED_BYTE;
    else if (a > PARAM_SPACE_END)
      b = ERASED_BYTE;
    else
      case (a[7:0])
        8'h00: b = SIG_0;
        8'h01: b = SIG_1;
        8'h02: b = SIG_2;
        8'h03: b = SIG_3;
        8'h04: b = HDR_MINOR_REV;
        8'h05: b = HDR_MAJOR_REV;
        8'h06: b = HDR_COUNT;
        8'h07: b = HDR_UNUSED;
        8'h08: b = TBL_ID_LSB;
        8'h09: b = TBL_MINOR_REV;
        default: b = ERASED_BYTE;
      endcase
    return b;
  endfunction : fam_param_byte
endpackage : fam_pkg
`default_nettype wire

// >>> fam_array_map.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - 24-bit address; low 22 bits split into blocks, sectors, pages
// - program only clears bits, within one page
// - erase by sector, block or chip, never page
// - sectors span xxx000h to xxxfffh
// - four 256-byte security registers with lock bits
// - security register zero is read-only parameter data
// - registers one to three erase, program, lock independently
// - parameter-read returns separate parameter space bytes
// - header at zero, reserved 0010h, table 0030h
// - space ends 006fh, 0070h-00ffh reserved
// - byte zero holds ascii S
// - bytes 1-3 hold F, D, P
// - revisions 06h/01h, count zero, byte 7 ffh
module fam_array_map
  import fam_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire fam_req_type req,
  input wire logic [SEC_REG_COUNT-1:0] sec_lock,
  output fam_rsp_type rsp
);

  // storage is nonvolatile in silicon, so it is never cleared by reset
  logic [7:0] main_mem [0:ARRAY_BYTES-1];
  logic [7:0] sec_mem [0:(SEC_REG_COUNT-1)*SEC_REG_BYTES-1];

  fam_state_type state, next_state;
  logic [ARRAY_W-1:0] walk_addr, next_walk_addr;
  logic [ARRAY_W-1:0] walk_last, next_walk_last;
  logic walk_sec, next_walk_sec;
  logic [ARRAY_W-PAGE_LSB-1:0] page_base, next_page_base;
  logic page_open, next_page_open;
  logic [PAGE_LSB-1:0] col, next_col;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic ignored, next_ignored;

  logic main_we;
  logic [ARRAY_W-1:0] main_waddr;
  logic [7:0] main_wdata;
  logic sec_we;
  logic [9:0] sec_waddr;
  logic [7:0] sec_wdata;

  logic take;
  logic [ARRAY_W-1:0] arr_addr;
  logic [1:0] sec_sel;
  logic [9:0] sec_idx;
  logic sec_blocked;

  assign take = req.valid && (state == st_idle);
  assign arr_addr = req.addr[ARRAY_W-1:0];
  assign sec_sel = req.addr[SEC_SEL_LSB+1:SEC_SEL_LSB];
  assign sec_idx = {sec_sel - 2'd1, req.addr[PAGE_LSB-1:0]};
  // register zero is factory data and every locked register refuses changes
  assign sec_blocked = (sec_sel == 2'd0) || sec_lock[sec_sel];

  always_comb
  begin
    next_state = state;
    next_walk_addr = walk_addr;
    next_walk_last = walk_last;
    next_walk_sec = walk_sec;
    next_page_base = page_base;
    next_page_open = page_open;
    next_col = col;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_ignored = 1'b0;
    main_we = 1'b0;
    main_waddr = arr_addr;
    main_wdata = ERASED_BYTE;
    sec_we = 1'b0;
    sec_waddr = sec_idx;
    sec_wdata = ERASED_BYTE;
    case (state)
      st_erase:
      begin
        // one byte per clock keeps a single write port on the array
        if (walk_sec)
        begin
          sec_we = 1'b1;
          sec_waddr = walk_addr[9:0];
        end
        else
        begin
          main_we = 1'b1;
          main_waddr = walk_addr;
        end
        if (walk_addr == walk_last)
          next_state = st_idle;
        else
          next_walk_addr = walk_addr + 22'h000001;
      end
      default:
      begin
        if (take)
        begin
          case (req.op)
            op_read_array:
            begin
              next_rdata = main_mem[arr_addr];
              next_rvalid = 1'b1;
            end
            op_prog_start:
            begin
              next_page_base = arr_addr[ARRAY_W-1:PAGE_LSB];
              next_col = arr_addr[PAGE_LSB-1:0];
              next_page_open = 1'b1;
            end
            op_prog_data:
            begin
              if (page_open)
              begin
                // column wraps inside the open page, never into the next
                main_we = 1'b1;
                main_waddr = {page_base, col};
                main_wdata = main_mem[{page_base, col}] & req.data;
                next_col = col + 8'h01;
              end
              else
                next_ignored = 1'b1;
            end
            op_erase_sector:
            begin
              next_state = st_erase;
              next_walk_sec = 1'b0;
              next_walk_addr = {arr_addr[ARRAY_W-1:SECTOR_LSB], 12'h000};
              next_walk_last = {arr_addr[ARRAY_W-1:SECTOR_LSB], 12'hfff};
            end
            op_erase_block:
            begin
              next_state = st_erase;
              next_walk_sec = 1'b0;
              next_walk_addr = {arr_addr[ARRAY_W-1:BLOCK_LSB], 16'h0000};
              next_walk_last = {arr_addr[ARRAY_W-1:BLOCK_LSB], 16'hffff};
            end
            op_erase_chip:
            begin
              next_state = st_erase;
              next_walk_sec = 1'b0;
              next_walk_addr = 22'h000000;
              next_walk_last = 22'h3fffff;
            end
            op_read_sec:
            begin
              if (sec_sel == 2'd0)
                next_rdata = fam_param_byte({8'h00, req.addr[PAGE_LSB-1:0]});
              else
                next_rdata = sec_mem[sec_idx];
              next_rvalid = 1'b1;
            end
            op_prog_sec:
            begin
              if (sec_blocked)
                next_ignored = 1'b1;
              else
              begin
                sec_we = 1'b1;
                sec_wdata = sec_mem[sec_idx] & req.data;
              end
            end
            op_erase_sec:
            begin
              if (sec_blocked)
                next_ignored = 1'b1;
              else
              begin
                next_state = st_erase;
                next_walk_sec = 1'b1;
                next_walk_addr = {12'h000, sec_idx[9:8], 8'h00};
                next_walk_last = {12'h000, sec_idx[9:8], 8'hff};
              end
            end
            op_read_param:
            begin
              // separate space, never touches the main array
              if (req.addr[ADDR_W-1:16] != 8'h00)
                next_rdata = ERASED_BYTE;
              else
                next_rdata = fam_param_byte(req.addr[15:0]);
              next_rvalid = 1'b1;
            end
            default:
              next_ignored = 1'b1;
          endcase
          if (req.op != op_prog_data && req.op != op_prog_start)
            next_page_open = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= st_idle;
      walk_addr <= '0;
      walk_last <= '0;
      walk_sec <= 1'b0;
      page_base <= '0;
      page_open <= 1'b0;
      col <= '0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      ignored <= 1'b0;
    end
    else
    begin
      state <= next_state;
      walk_addr <= next_walk_addr;
      walk_last <= next_walk_last;
      walk_sec <= next_walk_sec;
      page_base <= next_page_base;
      page_open <= next_page_open;
      col <= next_col;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      ignored <= next_ignored;
    end
  end

  always_ff @(posedge clock)
  begin
    if (main_we)
      main_mem[main_waddr] <= main_wdata;
    if (sec_we)
      sec_mem[sec_waddr] <= sec_wdata;
  end

  always_comb
  begin
    rsp.ready = (state == st_idle);
    rsp.busy = (state != st_idle);
    rsp.rvalid = rvalid;
    rsp.rdata = rdata;
    rsp.ignored = ignored;
  end

endmodule : fam_array_map
`default_nettype wire

// >>> fam_pkg_unused_guard.sv
`default_nettype none
`default_nettype wire

// >>> fam_array_map_props.sv
`timescale 1ns/100ps
`default_nettype none
module fam_array_map_props
  import fam_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire fam_req_type req,
  input wire logic [SEC_REG_COUNT-1:0] sec_lock,
  input wire fam_rsp_type rsp
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic take;
  logic sec_req;
  assign take = req.valid && rsp.ready;
  assign sec_req = take && req.op inside {op_prog_sec, op_erase_sec};
  a_busy_cause: assert property ($rose(rsp.busy) |-> $past(take)
    && $past(req.op) inside {op_erase_sector, op_erase_block, op_erase_chip, op_erase_sec})
    else $error("busy without an accepted erase");
  a_read_answer: assert property (take && req.op inside {op_read_array, op_read_sec,
    op_read_param} |=> rsp.rvalid && !rsp.ignored)
    else $error("read gave no data pulse");
  a_param_sig: assert property (take && req.op == op_read_param && req.addr == 24'h000000
    |=> rsp.rdata == 8'h53)
    else $error("signature byte wrong");
  a_param_rsvd: assert property (take && req.op == op_read_param
    && req.addr inside {[24'h000070:24'h0000ff]} |=> rsp.rdata == 8'hff)
    else $error("reserved byte not ff");
  a_sec0_locked: assert property (sec_req && req.addr[13:12] == 2'h0
    |=> rsp.ignored && !rsp.busy)
    else $error("register zero was altered");
  a_lock_refuse: assert property (sec_req && sec_lock[req.addr[13:12]]
    |=> rsp.ignored && !rsp.busy)
    else $error("locked register accepted a change");
  a_sec_erase_len: assert property (sec_req && req.op == op_erase_sec
    && req.addr[13:12] != 2'h0 && !sec_lock[req.addr[13:12]]
    |=> rsp.busy [*8] ##248 rsp.busy ##1 !rsp.busy)
    else $error("register erase length wrong");
  a_busy_refuse: assert property (rsp.busy && req.valid |=> !rsp.rvalid && !rsp.ignored)
    else $error("request taken while busy");
  a_sector_busy: assert property (take && req.op == op_erase_sector |=> rsp.busy [*8])
    else $error("sector erase not busy");
  c_sector: cover property (take && req.op == op_erase_sector);
  c_refused: cover property (rsp.ignored);
  c_prog: cover property (take && req.op == op_prog_data);
  c_block: cover property (take && req.op == op_erase_block);
endmodule : fam_array_map_props
bind fam_array_map fam_array_map_props chk (.clock(clock), .rst(rst), .req(req),
  .sec_lock(sec_lock), .rsp(rsp));
`default_nettype wire

// >>> fam_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module fam_host_model
  import fam_pkg::*;
(
  input wire logic clock,
  input wire fam_rsp_type rsp,
  output fam_req_type req
);
  initial req = '0;
  // one request per call; released fields are inverted so stale values never look valid
  task automatic do_op(input fam_op_type op, input logic [23:0] addr, input logic [7:0] data,
    output logic [7:0] rd, output logic ign);
    int n;
    n = 0;
    @(negedge clock);
    req = '{valid: 1'b1, op: op, addr: addr, data: data};
    // ready is settled at the falling edge, so the next rising edge takes the request
    while (!rsp.ready && n < 5000)
    begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    @(negedge clock);
    rd = rsp.rdata;
    ign = rsp.ignored;
    req.valid = 1'b0;
    req.addr = ~addr;
    req.data = ~data;
  endtask : do_op
endmodule : fam_host_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fam_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sec_lock = 4'h0;
  fam_req_type req;
  fam_rsp_type rsp;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic ig;
  always #4 clock = ~clock;
  fam_array_map uut (.clock(clock), .rst(rst), .req(req), .sec_lock(sec_lock), .rsp(rsp));
  fam_host_model host (.clock(clock), .rsp(rsp), .req(req));
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : check
  task automatic check_count(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s exp %0d got %0d", n, e, g);
    end
  endtask : check_count
  task automatic busy_len(output int n);
    n = 0;
    while (rsp.busy)
    begin
      @(negedge clock);
      n++;
    end
  endtask : busy_len
  task automatic op(input fam_op_type o, input logic [23:0] a, input logic [7:0] d);
    host.do_op(o, a, d, rd, ig);
  endtask : op
  task automatic t_param;
    logic [7:0] hdr [8] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h00, 8'hff};
    for (int i = 0; i < 8; i++)
    begin
      op(op_read_param, 24'(i), 8'h00);
      check("param hdr", hdr[i], rd);
    end
    op(op_read_param, 24'h000010, 8'h00);
    check("param rsvd hdr", 8'hff, rd);
    op(op_read_param, 24'h000070, 8'h00);
    check("param rsvd 70", 8'hff, rd);
    op(op_read_param, 24'h0000ff, 8'h00);
    check("param rsvd ff", 8'hff, rd);
  endtask : t_param
  task automatic t_array;
    int n;
    op(op_erase_sector, 24'h005abc, 8'h00);
    check("busy", 8'h01, {7'h0, rsp.busy});
    busy_len(n);
    check_count("sector erase cycles", 32'(1) << SECTOR_LSB, n);
    op(op_read_array, 24'h005000, 8'h00);
    check("sector low", 8'hff, rd);
    op(op_read_array, 24'h005fff, 8'h00);
    check("sector high", 8'hff, rd);
    op(op_prog_start, 24'h0050fe, 8'h00);
    op(op_prog_data, 24'h000000, 8'ha5);
    op(op_prog_data, 24'h000000, 8'h3c);
    op(op_prog_data, 24'h000000, 8'h0f);
    op(op_read_array, 24'h0050ff, 8'h00);
    check("page col ff", 8'h3c, rd);
    op(op_read_array, 24'h005000, 8'h00);
    check("page wrap", 8'h0f, rd);
    op(op_read_array, 24'h005100, 8'h00);
    check("next page", 8'hff, rd);
    op(op_prog_start, 24'h0050fe, 8'h00);
    op(op_prog_data, 24'h000000, 8'hf0);
    op(op_read_array, 24'hc050fe, 8'h00);
    check("and program", 8'ha0, rd);
  endtask : t_array
  task automatic t_secreg;
    op(op_erase_sec, 24'h001000, 8'h00);
    op(op_erase_sec, 24'h002000, 8'h00);
    op(op_prog_sec, 24'h001010, 8'h5a);
    op(op_read_sec, 24'h001010, 8'h00);
    check("sec1 prog", 8'h5a, rd);
    op(op_read_sec, 24'h002010, 8'h00);
    check("sec2 kept", 8'hff, rd);
    sec_lock = 4'h4;
    op(op_prog_sec, 24'h002010, 8'h55);
    check("locked prog", 8'h01, {7'h0, ig});
    op(op_erase_sec, 24'h002000, 8'h00);
    check("locked erase", 8'h01, {7'h0, ig});
    op(op_read_sec, 24'h002010, 8'h00);
    check("locked data", 8'hff, rd);
    op(op_prog_sec, 24'h000000, 8'h00);
    check("sec0 prog", 8'h01, {7'h0, ig});
    op(op_read_sec, 24'h000000, 8'h00);
    check("sec0 data", 8'h53, rd);
  endtask : t_secreg
  task automatic t_refuse;
    op(op_prog_data, 24'h000000, 8'h00);
    check("orphan data", 8'h01, {7'h0, ig});
    op(fam_op_type'(4'hb), 24'h000000, 8'h00);
    check("bad op", 8'h01, {7'h0, ig});
  endtask : t_refuse
  task automatic t_block;
    int n;
    op(op_erase_block, 24'h00a123, 8'h00);
    busy_len(n);
    check_count("block erase cycles", 32'(1) << BLOCK_LSB, n);
    op(op_read_array, 24'h0050fe, 8'h00);
    check("block erased", 8'hff, rd);
    op(op_read_array, 24'h00ffff, 8'h00);
    check("block end", 8'hff, rd);
    op(op_erase_chip, 24'h000000, 8'h00);
    check("chip busy", 8'h01, {7'h0, rsp.busy});
    // a full chip walk is too long to run, so reset cuts it short
    rst = 1'b1;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    check("reset idle", 8'h01, {6'h0, rsp.busy, rsp.ready});
    op(op_read_param, 24'h000000, 8'h00);
    check("param after reset", 8'h53, rd);
  endtask : t_block
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // ceiling leaves room for one block erase, one sector erase and a few register erases
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      bad_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    t_param();
    t_array();
    t_secreg();
    t_refuse();
    t_block();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
